// >>> hdl/pip_pkg.sv
// Constants, register map and types for the per-port ingress policy block.
// Assumes a 10 MHz clock and a 32-bit AHB-Lite register bus with word registers.
package pip_pkg;

  // Register byte offsets.
  localparam logic [7:0] PIP_REG_CTRL = 8'h00;
  localparam logic [7:0] PIP_REG_RISE = 8'h04;
  localparam logic [7:0] PIP_REG_FALL = 8'h08;
  localparam logic [7:0] PIP_REG_STAT = 8'h0c;
  localparam logic [7:0] PIP_REG_BCNT = 8'h10;

  // Control register field positions.
  localparam int PIP_CTRL_EN = 0;
  localparam int PIP_CTRL_FC = 1;
  localparam int PIP_CTRL_PRIO = 2;
  localparam int PIP_CTRL_LOCK = 4;
  localparam int PIP_CTRL_MODE = 5;
  localparam int PIP_CTRL_RACT = 8;
  localparam int PIP_CTRL_FACT = 10;
  localparam logic [31:0] PIP_CTRL_RST = 32'h0000_0003;

  // Threshold width and reset values, in frames per second.
  localparam int PIP_THR_W = 21;
  localparam logic [20:0] PIP_THR_MAX = 21'h16b480;
  localparam logic [20:0] PIP_RISE_RST = 21'h0001f4;
  localparam logic [20:0] PIP_FALL_RST = 21'h0000fa;

  // Measurement window: one second at the clock rate.
  localparam int PIP_CLK_PERIOD_NS = 100;
  localparam int PIP_WINDOW_MS = 1000;
  localparam int PIP_WINDOW_CYCLES = PIP_WINDOW_MS * 1000000 / PIP_CLK_PERIOD_NS;

  // Queue depth and pause watermarks, in frames held.
  localparam int PIP_QDEPTH = 8;
  localparam logic [4:0] PIP_PAUSE_ON = 5'h0c;
  localparam logic [4:0] PIP_PAUSE_OFF = 5'h04;

  // Settings.
  typedef enum logic [1:0] {PIP_PRIO_NORMAL, PIP_PRIO_HIGH, PIP_PRIO_LOW, PIP_PRIO_RSVD} pip_prio_t;
  typedef enum logic [2:0] {PIP_MODE_AUTO, PIP_MODE_100F, PIP_MODE_100H, PIP_MODE_10F,
                            PIP_MODE_10H, PIP_MODE_1000F, PIP_MODE_R6, PIP_MODE_R7} pip_mode_t;
  typedef enum logic [1:0] {PIP_ACT_NONE, PIP_ACT_BLOCK, PIP_ACT_BLOCK_TRAP,
                            PIP_ACT_RSVD} pip_act_t;

  // Drop reasons.
  localparam logic [2:0] PIP_WHY_DISABLED = 3'h1;
  localparam logic [2:0] PIP_WHY_LOCKED = 3'h2;
  localparam logic [2:0] PIP_WHY_STORM = 3'h3;
  localparam logic [2:0] PIP_WHY_FULL = 3'h4;

endpackage

// >>> hdl/pip_port_ingress.sv
// Per-port ingress policy: queue selection, port lock, pause and broadcast storm control.
// Assumes frame descriptors and dequeue requests come from the forwarding core on CLK;
// the link status pin comes from the PHY and is synchronised here.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module pip_port_ingress
  import pip_pkg::*;
#(
  parameter int WIN_CYCLES = PIP_WINDOW_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Received frame descriptors from the parser.
  input wire logic FRM_VALID,
  input wire logic [7:0] FRM_ID,
  input wire logic FRM_BCAST,
  input wire logic FRM_TAGGED,
  input wire logic [2:0] FRM_PCP,
  input wire logic FRM_SA_STATIC,
  // Dequeue toward the forwarding core.
  input wire logic DEQ_READY,
  output logic DEQ_VALID,
  output logic DEQ_HIGH,
  output logic [7:0] DEQ_ID,
  // Discard and learning reports.
  output logic DROP,
  output logic [2:0] DROP_WHY,
  output logic [7:0] DROP_ID,
  output logic LEARN,
  output logic [7:0] LEARN_ID,
  // Storm notification toward the management agent.
  output logic TRAP,
  output logic TRAP_FALL,
  // Link side.
  input wire logic LINK_UP,
  input wire logic GIGA_PORT,
  input wire logic [2:0] TREE_PORT_STATE,
  output logic PORT_ON,
  output logic [2:0] LINK_MODE,
  output logic PAUSE
);

  typedef enum logic {ST_CALM, ST_STORM} pip_storm_t;

  localparam logic [23:0] WIN_LAST = 24'(WIN_CYCLES - 1);
  localparam logic [2:0] QLAST = 3'(PIP_QDEPTH - 1);
  localparam logic [3:0] QFULL = 4'(PIP_QDEPTH);

  // Configuration registers.
  logic [31:0] ctrl_r;
  logic [20:0] rise_r;
  logic [20:0] fall_r;
  logic port_en;
  logic flow_on;
  pip_prio_t prio;
  logic lock_on;
  pip_act_t rise_act;
  pip_act_t fall_act;

  // Bus data phase state.
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic addr_ok;

  // Synchronisers for pins.
  logic link_m_r;
  logic link_r;
  logic giga_m_r;
  logic giga_r;

  // Queues.
  logic [7:0] qhi_mem [PIP_QDEPTH];
  logic [7:0] qlo_mem [PIP_QDEPTH];
  logic [2:0] qhi_wp_r;
  logic [2:0] qhi_rp_r;
  logic [2:0] qlo_wp_r;
  logic [2:0] qlo_rp_r;
  logic [3:0] qhi_n_r;
  logic [3:0] qlo_n_r;
  logic [4:0] occ;
  logic pause_r;

  // Storm control.
  pip_storm_t storm_r;
  logic block_r;
  logic [23:0] win_r;
  logic [20:0] bcnt_r;
  logic [20:0] blast_r;
  logic win_end;
  logic bc_seen;
  logic rise_hit;
  logic fall_hit;

  // Per-frame decisions.
  logic to_high;
  logic admit;
  logic push_hi;
  logic push_lo;
  logic pop_hi;
  logic pop_lo;
  logic [2:0] why;

  // Field views of the control register.
  assign port_en = ctrl_r[PIP_CTRL_EN];
  assign flow_on = ctrl_r[PIP_CTRL_FC];
  assign prio = pip_prio_t'(ctrl_r[PIP_CTRL_PRIO +: 2]);
  assign lock_on = ctrl_r[PIP_CTRL_LOCK];
  assign rise_act = pip_act_t'(ctrl_r[PIP_CTRL_RACT +: 2]);
  assign fall_act = pip_act_t'(ctrl_r[PIP_CTRL_FACT +: 2]);

  // Zero wait state slave; errors are never signalled.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rd_r;

  // Address phase is taken whenever selected with a valid transfer and the bus is ready.
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  // Write address is held for the data phase that follows.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (CE) begin
      wr_pend_r <= addr_ok && HWRITE;
      if (addr_ok) begin
        wr_addr_r <= HADDR[7:0];
      end
    end
  end

  // Writable registers; status offsets ignore writes so the indications stay truthful.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_r <= PIP_CTRL_RST;
      rise_r <= PIP_RISE_RST;
      fall_r <= PIP_FALL_RST;
    end else if (CE && wr_pend_r) begin
      case (wr_addr_r)
        PIP_REG_CTRL: ctrl_r <= {20'h00000, HWDATA[11:0]};
        // Out-of-range values are clamped into 1..1488000.
        PIP_REG_RISE: rise_r <= clamp_thr(HWDATA);
        PIP_REG_FALL: fall_r <= clamp_thr(HWDATA);
        default: ;
      endcase
    end
  end

  function automatic logic [20:0] clamp_thr(input logic [31:0] v);
    logic [20:0] r;
    r = v[20:0];
    if (v == 32'h0000_0000) begin
      r = 21'h000001;
    end else if (v > {11'h000, PIP_THR_MAX}) begin
      r = PIP_THR_MAX;
    end
    return r;
  endfunction

  // Read mux for the address phase; unmapped words read as zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (HADDR[7:0])
      PIP_REG_CTRL: rd_nxt = ctrl_r;
      PIP_REG_RISE: rd_nxt = {11'h000, rise_r};
      PIP_REG_FALL: rd_nxt = {11'h000, fall_r};
      PIP_REG_STAT: rd_nxt = {14'h0000, qlo_n_r, qhi_n_r, LINK_MODE, pause_r, block_r,
                              (storm_r == ST_STORM), TREE_PORT_STATE, link_r};
      PIP_REG_BCNT: rd_nxt = {11'h000, blast_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase and stands through the data phase.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_r <= 32'h0000_0000;
    end else if (CE && addr_ok && !HWRITE) begin
      rd_r <= rd_nxt;
    end
  end

  // Two-stage synchronisers for the PHY link pin and the gigabit strap.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      link_m_r <= 1'b0;
      link_r <= 1'b0;
      giga_m_r <= 1'b0;
      giga_r <= 1'b0;
    end else if (CE) begin
      link_m_r <= LINK_UP;
      link_r <= link_m_r;
      giga_m_r <= GIGA_PORT;
      giga_r <= giga_m_r;
    end
  end

  // Port enable and link mode go to the PHY; a gigabit port reports fixed 1000 full.
  assign PORT_ON = port_en;
  always_comb begin
    if (giga_r) begin
      LINK_MODE = PIP_MODE_1000F;
    end else if (ctrl_r[PIP_CTRL_MODE +: 3] > PIP_MODE_10H) begin
      LINK_MODE = PIP_MODE_AUTO;
    end else begin
      LINK_MODE = ctrl_r[PIP_CTRL_MODE +: 3];
    end
  end

  // Queue choice from the port setting or the frame's priority tag.
  always_comb begin
    case (prio)
      PIP_PRIO_HIGH: to_high = 1'b1;
      PIP_PRIO_LOW: to_high = 1'b0;
      // Untagged frames go low; tagged frames split at priority four.
      PIP_PRIO_NORMAL: to_high = FRM_TAGGED && FRM_PCP[2];
      default: to_high = 1'b0;
    endcase
  end

  // Admission checks in priority order: port off, lock, storm blocking, queue full.
  always_comb begin
    why = 3'h0;
    if (!port_en) begin
      why = PIP_WHY_DISABLED;
    end else if (lock_on && !FRM_SA_STATIC) begin
      why = PIP_WHY_LOCKED;
    end else if (FRM_BCAST && (block_r || (rise_hit && rise_act != PIP_ACT_NONE))) begin
      // The frame that reaches the threshold is itself dropped when blocking starts.
      why = PIP_WHY_STORM;
    end else if (to_high ? (qhi_n_r == QFULL) : (qlo_n_r == QFULL)) begin
      why = PIP_WHY_FULL;
    end
  end

  assign admit = FRM_VALID && (why == 3'h0);
  assign push_hi = admit && to_high;
  assign push_lo = admit && !to_high;

  // Strict priority: the low queue is offered only while the high queue is empty.
  assign DEQ_VALID = port_en && ((qhi_n_r != 4'h0) || (qlo_n_r != 4'h0));
  assign DEQ_HIGH = (qhi_n_r != 4'h0);
  assign DEQ_ID = DEQ_HIGH ? qhi_mem[qhi_rp_r] : qlo_mem[qlo_rp_r];
  assign pop_hi = DEQ_VALID && DEQ_READY && DEQ_HIGH;
  assign pop_lo = DEQ_VALID && DEQ_READY && !DEQ_HIGH;

  // Queue storage.
  always_ff @(posedge CLK) begin
    if (CE && push_hi) begin
      qhi_mem[qhi_wp_r] <= FRM_ID;
    end
    if (CE && push_lo) begin
      qlo_mem[qlo_wp_r] <= FRM_ID;
    end
  end

  // Queue pointers and counts; disabling the port flushes both queues.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      qhi_wp_r <= 3'h0;
      qhi_rp_r <= 3'h0;
      qhi_n_r <= 4'h0;
      qlo_wp_r <= 3'h0;
      qlo_rp_r <= 3'h0;
      qlo_n_r <= 4'h0;
    end else if (CE) begin
      if (!port_en) begin
        qhi_wp_r <= 3'h0;
        qhi_rp_r <= 3'h0;
        qhi_n_r <= 4'h0;
        qlo_wp_r <= 3'h0;
        qlo_rp_r <= 3'h0;
        qlo_n_r <= 4'h0;
      end else begin
        if (push_hi) begin
          qhi_wp_r <= (qhi_wp_r == QLAST) ? 3'h0 : qhi_wp_r + 3'h1;
        end
        if (pop_hi) begin
          qhi_rp_r <= (qhi_rp_r == QLAST) ? 3'h0 : qhi_rp_r + 3'h1;
        end
        qhi_n_r <= qhi_n_r + {3'h0, push_hi} - {3'h0, pop_hi};
        if (push_lo) begin
          qlo_wp_r <= (qlo_wp_r == QLAST) ? 3'h0 : qlo_wp_r + 3'h1;
        end
        if (pop_lo) begin
          qlo_rp_r <= (qlo_rp_r == QLAST) ? 3'h0 : qlo_rp_r + 3'h1;
        end
        qlo_n_r <= qlo_n_r + {3'h0, push_lo} - {3'h0, pop_lo};
      end
    end
  end

  // Pause with hysteresis so the partner is not toggled on every frame.
  assign occ = {1'b0, qhi_n_r} + {1'b0, qlo_n_r};
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pause_r <= 1'b0;
    end else if (CE) begin
      if (!port_en || !flow_on) begin
        pause_r <= 1'b0;
      end else if (occ >= PIP_PAUSE_ON) begin
        pause_r <= 1'b1;
      end else if (occ <= PIP_PAUSE_OFF) begin
        pause_r <= 1'b0;
      end
    end
  end
  assign PAUSE = pause_r;

  // Drop and learning reports, one cycle after the descriptor.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DROP <= 1'b0;
      DROP_WHY <= 3'h0;
      DROP_ID <= 8'h00;
      LEARN <= 1'b0;
      LEARN_ID <= 8'h00;
    end else if (CE) begin
      DROP <= FRM_VALID && (why != 3'h0);
      LEARN <= admit && !lock_on;
      if (FRM_VALID) begin
        DROP_WHY <= why;
        DROP_ID <= FRM_ID;
        LEARN_ID <= FRM_ID;
      end
    end
  end

  // One-second window counter.
  assign win_end = (win_r == WIN_LAST);
  always_ff @(posedge CLK) begin
    if (RESET) begin
      win_r <= 24'h000000;
    end else if (CE) begin
      win_r <= win_end ? 24'h000000 : win_r + 24'h000001;
    end
  end

  // Broadcast frames seen while the port is on, blocked ones included.
  assign bc_seen = FRM_VALID && FRM_BCAST && port_en;

  // Rising is detected the moment the running count reaches the threshold.
  assign rise_hit = bc_seen && (storm_r == ST_CALM) && (bcnt_r + 21'h000001 >= rise_r);
  // Falling is judged only on a completed window of a port in storm.
  assign fall_hit = win_end && (storm_r == ST_STORM) && (bcnt_r <= fall_r);

  // Broadcast counting; the count saturates rather than wraps.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bcnt_r <= 21'h000000;
      blast_r <= 21'h000000;
    end else if (CE) begin
      if (win_end) begin
        blast_r <= bcnt_r;
        bcnt_r <= {20'h00000, bc_seen};
      end else if (bc_seen && bcnt_r != 21'h1fffff) begin
        bcnt_r <= bcnt_r + 21'h000001;
      end
    end
  end

  // Storm state and blocking. Software keeps rising above falling, else the port may oscillate.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      storm_r <= ST_CALM;
      block_r <= 1'b0;
    end else if (CE) begin
      case (storm_r)
        ST_CALM: begin
          if (rise_hit) begin
            storm_r <= ST_STORM;
            block_r <= (rise_act != PIP_ACT_NONE);
          end
        end
        ST_STORM: begin
          if (fall_hit) begin
            storm_r <= ST_CALM;
            if (fall_act != PIP_ACT_NONE) begin
              block_r <= 1'b0;
            end
          end
        end
        default: storm_r <= ST_CALM;
      endcase
      // A blocking port with falling action do nothing stays blocked until disabled, reset, or a new rise with rising action do nothing.
      if (!port_en) begin
        storm_r <= ST_CALM;
        block_r <= 1'b0;
      end
    end
  end

  // Notification pulse for actions that include a trap.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TRAP <= 1'b0;
      TRAP_FALL <= 1'b0;
    end else if (CE) begin
      TRAP <= (rise_hit && rise_act == PIP_ACT_BLOCK_TRAP)
              || (fall_hit && fall_act == PIP_ACT_BLOCK_TRAP);
      if (rise_hit || fall_hit) begin
        TRAP_FALL <= fall_hit;
      end
    end
  end

endmodule

// >>> tb/pip_port_ingress_asserts.sv
// Concurrent checks on the ports of the ingress policy block.
// Assumes CE stays high while the bench runs traffic.
`timescale 1ns/1ps

module pip_port_ingress_asserts
  import pip_pkg::*;
#(
  parameter int WIN_CYCLES = PIP_WINDOW_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // Frame, dequeue and report side.
  input wire logic FRM_VALID,
  input wire logic [7:0] FRM_ID,
  input wire logic FRM_BCAST,
  input wire logic FRM_SA_STATIC,
  input wire logic DEQ_READY,
  input wire logic DEQ_VALID,
  input wire logic DEQ_HIGH,
  input wire logic [7:0] DEQ_ID,
  input wire logic DROP,
  input wire logic [2:0] DROP_WHY,
  input wire logic [7:0] DROP_ID,
  input wire logic LEARN,
  input wire logic [7:0] LEARN_ID,
  // Link side.
  input wire logic GIGA_PORT,
  input wire logic PORT_ON,
  input wire logic [2:0] LINK_MODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // A port that is off offers nothing and discards every frame.
  property p_off_idle;
    !PORT_ON |-> !DEQ_VALID;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Offer while port off.");
  property p_off_drop;
    FRM_VALID && CE && !PORT_ON |=> DROP && DROP_WHY == PIP_WHY_DISABLED
      && DROP_ID == $past(FRM_ID);
  endproperty
  a_off_drop: assert property (p_off_drop) else $error("Frame not refused.");
  // Discard reasons must match the frame that caused them.
  property p_lock_src;
    DROP && DROP_WHY == PIP_WHY_LOCKED |-> $past(FRM_VALID && !FRM_SA_STATIC);
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("Static source refused.");
  property p_storm_bc;
    DROP && DROP_WHY == PIP_WHY_STORM |-> $past(FRM_BCAST);
  endproperty
  a_storm_bc: assert property (p_storm_bc) else $error("Unicast storm drop.");
  property p_learn_id;
    LEARN |-> !DROP && $past(FRM_VALID) && LEARN_ID == $past(FRM_ID);
  endproperty
  a_learn_id: assert property (p_learn_id) else $error("Learn without frame.");
  // An admitted unicast from a listed source lands in a queue next cycle.
  property p_enq;
    FRM_VALID && CE && PORT_ON && !FRM_BCAST && FRM_SA_STATIC
      |=> DEQ_VALID || (DROP && DROP_WHY == PIP_WHY_FULL);
  endproperty
  a_enq: assert property (p_enq) else $error("Frame lost.");
  // A waiting high frame keeps the head; nothing low may overtake it.
  property p_high_hold;
    DEQ_VALID && DEQ_HIGH && !DEQ_READY && CE ##1 PORT_ON |-> DEQ_HIGH && $stable(DEQ_ID);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("High head lost.");
  // The gigabit strap reaches the mode after its two synchroniser stages.
  property p_giga;
    (GIGA_PORT && CE) [*4] |-> LINK_MODE == PIP_MODE_1000F;
  endproperty
  a_giga: assert property (p_giga) else $error("Gigabit mode missing.");
  property p_no_giga;
    (!GIGA_PORT) [*4] |-> LINK_MODE != PIP_MODE_1000F;
  endproperty
  a_no_giga: assert property (p_no_giga) else $error("Gigabit mode shown.");
endmodule

bind pip_port_ingress pip_port_ingress_asserts #(.WIN_CYCLES(WIN_CYCLES))
  u_pip_port_ingress_asserts (.CLK(CLK), .RESET(RESET), .CE(CE), .FRM_VALID(FRM_VALID),
  .FRM_ID(FRM_ID), .FRM_BCAST(FRM_BCAST), .FRM_SA_STATIC(FRM_SA_STATIC),
  .DEQ_READY(DEQ_READY), .DEQ_VALID(DEQ_VALID), .DEQ_HIGH(DEQ_HIGH), .DEQ_ID(DEQ_ID),
  .DROP(DROP), .DROP_WHY(DROP_WHY), .DROP_ID(DROP_ID), .LEARN(LEARN),
  .LEARN_ID(LEARN_ID), .GIGA_PORT(GIGA_PORT), .PORT_ON(PORT_ON), .LINK_MODE(LINK_MODE));

// >>> tb/pip_link_partner.sv
// Link partner station and forwarding core facing the ingress block.
// Assumes the bench holds one frame request until it is taken.
`timescale 1ns/1ps

module pip_link_partner (
  // Clock.
  input wire logic clk,
  // Requests from the bench.
  input wire logic req,
  input wire logic [13:0] fields,
  input wire logic stall,
  input wire logic slow,
  // Toward the block.
  input wire logic pause,
  output logic frm_valid,
  output logic [13:0] frm_fields,
  output logic deq_ready
);
  logic [13:0] noise_r = 14'h0;
  logic coin_r = 1'b0;

  // Idle lines change every cycle so stale data never passes for a frame.
  always_ff @(posedge clk) begin
    noise_r <= noise_r + 14'h1;
    coin_r <= 1'($urandom_range(0, 1));
  end

  // The station holds its frame back while asked to pause.
  assign frm_valid = req && !pause;
  assign frm_fields = frm_valid ? fields : noise_r;
  // The core takes at once, never, or on a coin toss.
  assign deq_ready = !stall && (!slow || coin_r);
endmodule

// >>> tb/tb_port_ingress_policy.sv
// Self-checking bench for the per-port ingress policy block.
// Assumes a zero-wait AHB-Lite slave and a short storm window.
`timescale 1ns/1ps

module tb_port_ingress_policy;
  import pip_pkg::*;
  localparam int WIN = 200;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic CE = 1'b1, HSEL = 1'b1, HWRITE = 1'b0, LINK_UP = 1'b0, GIGA_PORT = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2, TREE_PORT_STATE = 3'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rq, s;
  logic HREADYOUT, HRESP, FRM_VALID, FRM_BCAST, FRM_TAGGED, FRM_SA_STATIC, DEQ_READY;
  logic DEQ_VALID, DEQ_HIGH, DROP, LEARN, TRAP, TRAP_FALL, PORT_ON, PAUSE;
  logic [2:0] FRM_PCP, DROP_WHY, LINK_MODE;
  logic [7:0] FRM_ID, DEQ_ID, DROP_ID, LEARN_ID;
  logic req = 1'b0, stall = 1'b0, slow = 1'b0, en = 1'b1, lock = 1'b0, blk = 1'b0;
  logic [13:0] fields = 14'h0;
  logic [1:0] prio = 2'h0, ract = 2'h0;
  logic [11:0] stage[$], qd[$];
  logic [7:0] qh[$], ql[$];
  int fail_count = 0, comparisons = 0, nh = 0, nl = 0, bcn = 0, rise = 500;
  int traps[2] = '{0, 0};

  pip_port_ingress #(.WIN_CYCLES(WIN)) u_pip_port_ingress (.CLK(CLK), .RESET(RESET),
    .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .FRM_VALID(FRM_VALID), .FRM_ID(FRM_ID), .FRM_BCAST(FRM_BCAST),
    .FRM_TAGGED(FRM_TAGGED), .FRM_PCP(FRM_PCP), .FRM_SA_STATIC(FRM_SA_STATIC),
    .DEQ_READY(DEQ_READY), .DEQ_VALID(DEQ_VALID), .DEQ_HIGH(DEQ_HIGH), .DEQ_ID(DEQ_ID),
    .DROP(DROP), .DROP_WHY(DROP_WHY), .DROP_ID(DROP_ID), .LEARN(LEARN),
    .LEARN_ID(LEARN_ID), .TRAP(TRAP), .TRAP_FALL(TRAP_FALL), .LINK_UP(LINK_UP),
    .GIGA_PORT(GIGA_PORT), .TREE_PORT_STATE(TREE_PORT_STATE), .PORT_ON(PORT_ON),
    .LINK_MODE(LINK_MODE), .PAUSE(PAUSE));
  pip_link_partner u_pip_link_partner (.clk(CLK), .req(req), .fields(fields),
    .stall(stall), .slow(slow), .pause(PAUSE), .frm_valid(FRM_VALID),
    .frm_fields({FRM_ID, FRM_BCAST, FRM_TAGGED, FRM_PCP, FRM_SA_STATIC}),
    .deq_ready(DEQ_READY));

  // Clock at 10 MHz.
  initial begin
    forever #50 CLK = ~CLK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single word transfer; read data lands in rq.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rq = HRDATA;
  endtask

  task automatic cfg(input logic e, input logic [1:0] p, input logic l, input logic [1:0] a,
                     input logic [1:0] f);
    en = e;
    prio = p;
    lock = l;
    ract = a;
    bus(1'b1, PIP_REG_CTRL, {20'h0, f, a, 3'h0, l, p, 1'b1, e});
  endtask

  // Notes the expected fate of a frame, then offers it until taken.
  task automatic send(input logic [7:0] id, input logic bc, input logic tg,
                      input logic [2:0] pcp, input logic st);
    logic hi;
    logic [2:0] why;
    hi = prio == PIP_PRIO_HIGH || (prio == PIP_PRIO_NORMAL && tg && pcp[2]);
    why = 3'h0;
    if (bc) bcn++;
    if (bc && ract != 2'h0 && bcn >= rise) blk = 1'b1;
    if (!en) why = PIP_WHY_DISABLED;
    else if (lock && !st) why = PIP_WHY_LOCKED;
    else if (bc && blk) why = PIP_WHY_STORM;
    else if (hi ? nh >= 8 : nl >= 8) why = PIP_WHY_FULL;
    else if (hi) nh++;
    else nl++;
    stage.push_back({why, hi, id});
    req <= 1'b1;
    fields <= {id, bc, tg, pcp, st};
    do @(posedge CLK); while (PAUSE !== 1'b0);
  endtask

  task automatic idle();
    req <= 1'b0;
    @(posedge CLK);
  endtask

  // Scoreboard: dequeues follow strict priority, discards follow the notes.
  always @(posedge CLK) begin
    logic [11:0] n;
    if (DEQ_VALID === 1'b1 && DEQ_READY) begin
      if (qh.size() > 0) begin
        nh--;
        check({DEQ_HIGH, DEQ_ID}, {1'b1, qh.pop_front()});
      end else begin
        nl--;
        check({DEQ_HIGH, DEQ_ID}, {1'b0, ql.pop_front()});
      end
    end
    if (FRM_VALID && stage.size() > 0) begin
      n = stage.pop_front();
      if (n[11:9] != 3'h0) qd.push_back({1'b0, n[11:9], n[7:0]});
      else if (n[8]) qh.push_back(n[7:0]);
      else ql.push_back(n[7:0]);
    end
    if (DROP === 1'b1) check({DROP_WHY, DROP_ID}, qd.pop_front());
    if (TRAP === 1'b1) traps[TRAP_FALL]++;
  end

  task automatic finish_test();
    $display("TB: comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the planned run.
  initial begin
    #3000000;
    fail_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    void'($urandom(45408));
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    LINK_UP <= 1'b1;
    TREE_PORT_STATE <= 3'($urandom_range(0, 7));
    bus(1'b0, PIP_REG_CTRL, 32'h0);
    check(rq, PIP_CTRL_RST);
    bus(1'b0, PIP_REG_RISE, 32'h0);
    check(rq, {11'h0, PIP_RISE_RST});
    bus(1'b0, PIP_REG_FALL, 32'h0);
    check(rq, {11'h0, PIP_FALL_RST});
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, i ? PIP_REG_FALL : PIP_REG_RISE, 32'h0);
      bus(1'b0, i ? PIP_REG_FALL : PIP_REG_RISE, 32'h0);
      check(rq, 32'h1);
      bus(1'b1, i ? PIP_REG_FALL : PIP_REG_RISE, 32'h001f_ffff);
      bus(1'b0, i ? PIP_REG_FALL : PIP_REG_RISE, 32'h0);
      check(rq, {11'h0, PIP_THR_MAX});
    end
    bus(1'b0, PIP_REG_STAT, 32'h0);
    s = rq;
    check(rq[3:0], {TREE_PORT_STATE, 1'b1});
    bus(1'b1, PIP_REG_STAT, ~s);
    bus(1'b0, PIP_REG_STAT, 32'h0);
    check(rq, s);
    bus(1'b1, 8'h20, $urandom);
    bus(1'b0, 8'h20, 32'h0);
    check(rq, 32'h0);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, PIP_REG_CTRL, {24'h0, 3'(m), 5'h03});
      // The write lands at the edge that ends the data phase; look one edge later.
      @(posedge CLK);
      check(LINK_MODE, m < 5 ? m : 0);
    end
    GIGA_PORT <= 1'b1;
    repeat (4) @(posedge CLK);
    check(LINK_MODE, PIP_MODE_1000F);
    GIGA_PORT <= 1'b0;
    // Every priority setting with random tags and a hesitant core.
    slow <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      cfg(1'b1, 2'(p), 1'b0, 2'h0, 2'h0);
      for (int k = 0; k < 8; k++) begin
        send(8'($urandom), 1'b0, 1'($urandom), 3'($urandom), 1'b1);
      end
      idle();
      repeat (30) @(posedge CLK);
    end
    // Stalled core: high queue overflows, then pause at twelve held.
    stall <= 1'b1;
    slow <= 1'b0;
    cfg(1'b1, PIP_PRIO_NORMAL, 1'b0, 2'h0, 2'h0);
    for (int k = 0; k < 13; k++) begin
      send(8'(k), 1'b0, k < 9, 3'h7, 1'b1);
    end
    idle();
    repeat (2) @(posedge CLK);
    check(PAUSE, 1'b1);
    stall <= 1'b0;
    for (int t = 0; t < 60 && qh.size() + ql.size() + stage.size() > 0; t++) @(posedge CLK);
    repeat (2) @(posedge CLK);
    check(qh.size() + ql.size() + stage.size(), 0);
    check(PAUSE, 1'b0);
    // Lock admits listed sources only, then the port is turned off.
    cfg(1'b1, PIP_PRIO_NORMAL, 1'b1, 2'h0, 2'h0);
    send(8'h40, 1'b0, 1'b0, 3'h0, 1'b1);
    send(8'h41, 1'b0, 1'b0, 3'h0, 1'b0);
    idle();
    cfg(1'b0, PIP_PRIO_NORMAL, 1'b0, 2'h0, 2'h0);
    @(posedge CLK);
    check(PORT_ON, 1'b0);
    send(8'h50, 1'b0, 1'b0, 3'h0, 1'b1);
    idle();
    cfg(1'b1, PIP_PRIO_NORMAL, 1'b0, 2'h0, 2'h0);
    // Storm with no action forwards; later block with trap, then forward.
    bus(1'b1, PIP_REG_FALL, 32'h1);
    bus(1'b1, PIP_REG_RISE, 32'h3);
    rise = 3;
    for (int k = 0; k < 4; k++) send(8'(8'h60 + k), 1'b1, 1'b0, 3'h0, 1'b1);
    idle();
    repeat (2 * WIN + 20) @(posedge CLK);
    cfg(1'b1, PIP_PRIO_NORMAL, 1'b0, 2'h2, 2'h2);
    bcn = 0;
    send(8'h70, 1'b1, 1'b0, 3'h0, 1'b1);
    idle();
    for (int t = 0; t < 200 && rq !== 32'h1; t++) bus(1'b0, PIP_REG_BCNT, 32'h0);
    check(rq, 32'h1);
    bcn = 0;
    for (int k = 0; k < 4; k++) send(8'(8'h71 + k), 1'b1, 1'b0, 3'h0, 1'b1);
    idle();
    repeat (2 * WIN + 20) @(posedge CLK);
    // Falling forward ends blocking and the storm; a new window counts from zero.
    blk = 1'b0;
    bcn = 0;
    bus(1'b0, PIP_REG_BCNT, 32'h0);
    check(rq, 32'h0);
    send(8'h7a, 1'b1, 1'b0, 3'h0, 1'b1);
    idle();
    repeat (5) @(posedge CLK);
    check(traps[0], 1);
    check(traps[1], 1);
    finish_test();
  end
endmodule
